/* File: ssp_regs.svh */
// constants of the supply-line serial command port
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define SSP_RD_BITS 6'h10
`define SSP_WR_BITS 6'h20
`define SSP_RD_SYNC 15:14
`define SSP_WR_SYNC 31:30
`define SSP_RD_PAY 13:3
`define SSP_WR_PAY 29:3
`define SSP_CHK 2:0
`define SSP_F_RW 26
`define SSP_F_TGT 25:22
`define SSP_F_ADDR 21:16
`define SSP_F_DATA 15:0
`define SSP_RD_LEN 5'h0b
`define SSP_WR_LEN 5'h1b
`define SSP_ACCESS_ADDR 6'h3f
`define SSP_ACCESS_KEY 16'h62d2
`define SSP_CRC_POLY 3'h3
`define SSP_CRC_PRESET 3'h7
`define SSP_RSP_LAST 5'h14
`endif

/* File: ssp_pkg.sv */
// types and check-field function of the serial command port
`include "ssp_regs.svh"
package ssp_pkg;
    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_MEAS = 2'b01,
        SSP_BITS = 2'b10
    } ssp_rx_state_t;

    // msb first over the low n bits of d
    function automatic logic [2:0] ssp_crc3(input logic [26:0] d, input logic [4:0] n);
        logic [2:0] c;
        logic fb;
        c = `SSP_CRC_PRESET;
        fb = 1'b0;
        for (int i = 26; i >= 0; i--) begin
            if (i < int'(n)) begin
                fb = d[i] ^ c[2];
                c = {c[1:0], 1'b0} ^ ({3{fb}} & `SSP_CRC_POLY);
            end
        end
        return c;
    endfunction
endpackage

/* File: ssp_tx_if.sv */
// link between the frame decoder and the answer transmitter
`timescale 1ns/1ps
interface ssp_tx_if #(parameter int CNT_W = 16);
    logic ce;
    logic start;
    logic abort;
    logic [15:0] data;
    logic [CNT_W-1:0] half;
    logic busy;
    logic drive_low;
    modport ctl(output ce, start, abort, data, half, input busy, drive_low);
    modport tx(input ce, start, abort, data, half, output busy, drive_low);
endinterface

/* File: ssp_tx.sv */
// manchester answer transmitter at the measured half-bit time
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_tx #(parameter int CNT_W = 16) (
    input wire logic clock,
    input wire logic rstn,
    ssp_tx_if.tx tx
);
    logic busy_reg;
    logic phase_reg;
    logic [20:0] sh_reg;
    logic [4:0] nbit_reg;
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            phase_reg <= 1'b0;
            sh_reg <= 21'h00_0000;
            nbit_reg <= 5'h00;
            cnt_reg <= '0;
        end else if (tx.ce) begin
            if (tx.abort) begin
                busy_reg <= 1'b0;
            end else if (tx.start && !busy_reg) begin
                // two zero sync bits, data msb first, then check field
                sh_reg <= {2'h0, tx.data, ssp_pkg::ssp_crc3({11'h000, tx.data}, 5'h10)};
                nbit_reg <= 5'h00;
                phase_reg <= 1'b0;
                cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (cnt_reg >= tx.half) begin
                    cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
                    phase_reg <= ~phase_reg;
                    if (phase_reg) begin
                        sh_reg <= {sh_reg[19:0], 1'b0};
                        nbit_reg <= nbit_reg + 5'h01;
                        busy_reg <= (nbit_reg != `SSP_RSP_LAST);
                    end
                end else begin
                    cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // first half carries the bit level, so a 0 rises mid-cell
    assign tx.drive_low = busy_reg & (phase_reg ? sh_reg[20] : ~sh_reg[20]);
    assign tx.busy = busy_reg;
endmodule // ssp_tx

/* File: ssp_port.sv */
// supply-line manchester command port: decoder, mode control, answers
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_port #(
    parameter int CNT_W = 16,
    parameter int MIN_HALF = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic supply_rx,
    input wire logic serial_supply_port_disable,
    input wire logic die_strap_low,
    input wire logic die_strap_high,
    input wire logic angle_pwm_low,
    input wire logic pwm_pin_in,
    output logic pwm_pin_out,
    output logic pwm_pin_oe,
    output logic reg_wr_valid,
    output logic [5:0] reg_wr_addr,
    output logic [15:0] reg_wr_data,
    output logic reg_rd_valid,
    output logic [5:0] reg_rd_addr,
    input wire logic [15:0] reg_rd_data,
    output logic comm_mode,
    output logic frame_crc_error
);
    // =====================================================
    // elaboration checks
    if (CNT_W < 4 || CNT_W > 24) begin : g_bad_cnt
        $error("CNT_W out of range");
    end
    if (MIN_HALF < 2 || MIN_HALF >= (1 << (CNT_W - 2))) begin : g_bad_min
        $error("MIN_HALF out of range");
    end

    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] HALF_MIN = CNT_W'(MIN_HALF);

    // =====================================================
    // state
    ssp_pkg::ssp_rx_state_t state_reg;
    logic rx_prev_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] half_reg;
    logic [5:0] nbit_reg;
    logic [31:0] shift_reg;
    logic [1:0] die_id_reg;
    logic strap_done_reg;
    logic comm_mode_reg;
    logic rd_pend_reg;
    logic wr_valid_reg;
    logic [5:0] wr_addr_reg;
    logic [15:0] wr_data_reg;
    logic [5:0] rd_addr_reg;
    logic crc_err_reg;
    logic pwm_oe_reg;

    ssp_tx_if #(.CNT_W(CNT_W)) txi ();

    // =====================================================
    // line edges and bit windows
    logic rise;
    logic fall;
    logic edge_seen;
    logic [CNT_W-1:0] win_lo;
    logic [CNT_W-1:0] win_hi;
    logic take_bit;
    logic frame_end;

    assign rise = ~rx_prev_reg & supply_rx;
    assign fall = rx_prev_reg & ~supply_rx;
    assign edge_seen = rise | fall;
    // cell boundary edges land near one half-bit and are skipped;
    // mid-cell edges land near two half-bits after the previous one
    assign win_lo = half_reg + (half_reg >> 1);
    assign win_hi = (half_reg << 1) + half_reg;
    assign take_bit = (state_reg == ssp_pkg::SSP_BITS) && edge_seen && (cnt_reg >= win_lo);
    assign frame_end = (state_reg == ssp_pkg::SSP_BITS) && !serial_supply_port_disable && !edge_seen
                       && (cnt_reg >= win_hi);

    // =====================================================
    // frame fields
    logic is_rd_len;
    logic is_wr_len;
    logic sync_ok;
    logic [26:0] pay;
    logic [4:0] pay_len;
    logic crc_ok;
    logic frame_ok;
    logic f_read;
    logic f_write;
    logic [3:0] f_tgt;
    logic [5:0] f_addr;
    logic [15:0] f_data;
    logic id_hit;
    logic is_ctrl;

    assign is_rd_len = (nbit_reg == `SSP_RD_BITS);
    assign is_wr_len = (nbit_reg == `SSP_WR_BITS);
    assign sync_ok = is_rd_len ? (shift_reg[`SSP_RD_SYNC] == 2'h0)
                               : (shift_reg[`SSP_WR_SYNC] == 2'h0);
    // reads are aligned to the write layout so field positions are shared
    assign pay = is_rd_len ? {shift_reg[`SSP_RD_PAY], 16'h0000} : shift_reg[`SSP_WR_PAY];
    assign pay_len = is_rd_len ? `SSP_RD_LEN : `SSP_WR_LEN;
    assign crc_ok = ssp_pkg::ssp_crc3(is_rd_len ? {16'h0000, shift_reg[`SSP_RD_PAY]}
                                                : shift_reg[`SSP_WR_PAY],
                                      pay_len) == shift_reg[`SSP_CHK];
    assign f_read = is_rd_len && pay[`SSP_F_RW];
    assign f_write = is_wr_len && !pay[`SSP_F_RW];
    assign f_tgt = pay[`SSP_F_TGT];
    assign f_addr = pay[`SSP_F_ADDR];
    assign f_data = pay[`SSP_F_DATA];
    assign frame_ok = frame_end && sync_ok && crc_ok && (f_read || f_write);
    assign id_hit = f_tgt[die_id_reg];
    assign is_ctrl = f_write && (f_addr == `SSP_ACCESS_ADDR);

    // =====================================================
    // die identity from straps, caught once after reset release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            die_id_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (clk_en && !strap_done_reg) begin
            die_id_reg <= {die_strap_high, die_strap_low};
            strap_done_reg <= 1'b1;
        end
    end

    // =====================================================
    // receiver: rate measurement and bit sampling
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_prev_reg <= 1'b1;
        end else if (clk_en) begin
            rx_prev_reg <= supply_rx;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ssp_pkg::SSP_IDLE;
            cnt_reg <= '0;
            half_reg <= HALF_MIN;
            nbit_reg <= 6'h00;
            shift_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (serial_supply_port_disable) begin
                state_reg <= ssp_pkg::SSP_IDLE;
            end else begin
                unique case (state_reg)
                    ssp_pkg::SSP_IDLE: begin
                        // idle line is high; the first sync cell opens low
                        if (fall) begin
                            state_reg <= ssp_pkg::SSP_MEAS;
                            cnt_reg <= CNT_ONE;
                        end
                    end
                    ssp_pkg::SSP_MEAS: begin
                        if (rise) begin
                            // first half cell sets the rate for this frame
                            half_reg <= cnt_reg;
                            cnt_reg <= CNT_ONE;
                            nbit_reg <= 6'h01;
                            shift_reg <= 32'h0000_0000;
                            state_reg <= (cnt_reg < HALF_MIN) ? ssp_pkg::SSP_IDLE
                                                               : ssp_pkg::SSP_BITS;
                        end else if (fall || cnt_reg == CNT_MAX) begin
                            state_reg <= ssp_pkg::SSP_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + CNT_ONE;
                        end
                    end
                    ssp_pkg::SSP_BITS: begin
                        if (take_bit) begin
                            // falling mid-cell edge carries a one
                            shift_reg <= {shift_reg[30:0], fall};
                            nbit_reg <= (nbit_reg == 6'h3f) ? nbit_reg : nbit_reg + 6'h01;
                            cnt_reg <= CNT_ONE;
                        end else if (frame_end) begin
                            state_reg <= ssp_pkg::SSP_IDLE;
                        end else if (cnt_reg != CNT_MAX) begin
                            cnt_reg <= cnt_reg + CNT_ONE;
                        end
                    end
                    default: begin
                        state_reg <= ssp_pkg::SSP_IDLE;
                    end
                endcase
            end
        end
    end

    // =====================================================
    // mode control
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            comm_mode_reg <= 1'b0;
        end else if (clk_en && frame_ok && is_ctrl) begin
            // broadcast: the target mask is not looked at
            comm_mode_reg <= (f_data == `SSP_ACCESS_KEY);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            crc_err_reg <= 1'b0;
        end else if (clk_en) begin
            crc_err_reg <= frame_end && sync_ok && (is_rd_len || is_wr_len) && !crc_ok;
        end
    end

    // =====================================================
    // register writes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_valid_reg <= 1'b0;
            wr_addr_reg <= 6'h00;
            wr_data_reg <= 16'h0000;
        end else if (clk_en) begin
            // nothing but the access frame acts outside communication mode
            wr_valid_reg <= frame_ok && f_write && !is_ctrl && comm_mode_reg
                            && (f_tgt == 4'h0 || id_hit);
            if (frame_ok && f_write) begin
                wr_addr_reg <= f_addr;
                wr_data_reg <= f_data;
            end
        end
    end

    // =====================================================
    // read requests and answer start
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= 6'h00;
        end else if (clk_en) begin
            if (frame_ok && f_read && comm_mode_reg && id_hit && !txi.busy) begin
                rd_pend_reg <= 1'b1;
                rd_addr_reg <= f_addr;
            end else begin
                rd_pend_reg <= 1'b0;
            end
        end
    end

    // a read that arrives while an answer is still going out is dropped
    assign txi.ce = clk_en;
    assign txi.start = rd_pend_reg && comm_mode_reg;
    assign txi.abort = !comm_mode_reg;
    assign txi.data = reg_rd_data;
    assign txi.half = half_reg;

    ssp_tx #(.CNT_W(CNT_W)) u_tx (
        .clock(clock),
        .rstn(rstn),
        .tx(txi)
    );

    // =====================================================
    // pulse-width pin: open drain, enable pulls low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pwm_oe_reg <= 1'b0;
        end else if (clk_en) begin
            // angle output is cut at once, even mid-pulse
            pwm_oe_reg <= comm_mode_reg ? txi.drive_low : angle_pwm_low;
        end
    end

    assign pwm_pin_out = 1'b0;
    assign pwm_pin_oe = pwm_oe_reg;
    assign reg_wr_valid = wr_valid_reg;
    assign reg_wr_addr = wr_addr_reg;
    assign reg_wr_data = wr_data_reg;
    assign reg_rd_valid = rd_pend_reg;
    assign reg_rd_addr = rd_addr_reg;
    assign comm_mode = comm_mode_reg;
    assign frame_crc_error = crc_err_reg;

    // =====================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_disable;
        clk_en && serial_supply_port_disable |=> state_reg == ssp_pkg::SSP_IDLE;
    endproperty
    a_disable: assert property (p_disable) else $error("port not idle while disabled");

    property p_access;
        clk_en && frame_ok && is_ctrl && f_data == `SSP_ACCESS_KEY |=> comm_mode_reg;
    endproperty
    a_access: assert property (p_access) else $error("access frame ignored");

    property p_exit;
        clk_en && frame_ok && is_ctrl && f_data != `SSP_ACCESS_KEY |=> !comm_mode_reg;
    endproperty
    a_exit: assert property (p_exit) else $error("exit frame ignored");

    property p_pin_mux;
        clk_en && comm_mode_reg && angle_pwm_low && !txi.drive_low |=> !pwm_pin_oe;
    endproperty
    a_pin_mux: assert property (p_pin_mux) else $error("angle drives pin in comm mode");

    property p_bad_crc;
        clk_en && frame_end && !crc_ok |=> !reg_wr_valid && !rd_pend_reg ##1 !txi.busy || $past(txi.busy);
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad frame had effect");

    property p_tx_cause;
        $rose(txi.busy) |-> $past(rd_pend_reg) && $past(comm_mode_reg);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("unsolicited answer");

    property p_target;
        clk_en && frame_ok && f_write && f_tgt != 4'h0 && !id_hit |=> !reg_wr_valid;
    endproperty
    a_target: assert property (p_target) else $error("write to other die taken");

    property p_strap;
        $rose(strap_done_reg) |-> die_id_reg == {$past(die_strap_high), $past(die_strap_low)};
    endproperty
    a_strap: assert property (p_strap) else $error("die identity wrong");

    property p_bit_value;
        clk_en && !serial_supply_port_disable && take_bit |=> shift_reg[0] == $past(fall);
    endproperty
    a_bit_value: assert property (p_bit_value) else $error("bit decoded wrong");

    property p_broadcast;
        clk_en && frame_ok && f_write && !is_ctrl && comm_mode_reg && f_tgt == 4'h0 |=> reg_wr_valid;
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast write lost");

    property p_read_take;
        clk_en && frame_ok && f_read && comm_mode_reg && id_hit && !txi.busy |=> reg_rd_valid ##1 txi.busy;
    endproperty
    a_read_take: assert property (p_read_take) else $error("valid read not answered");

    c_bad_frame: cover property (frame_crc_error);
    c_access: cover property (clk_en && frame_ok && is_ctrl ##1 comm_mode_reg);
    c_write: cover property (reg_wr_valid);
    c_answer: cover property (rd_pend_reg ##1 txi.busy);
endmodule // ssp_port

/* File: ssp_host.sv */
// host controller model: manchester frames on the supply line, answer decoding on the pin
`timescale 1ns/1ps
module ssp_host (
    input wire logic clock,
    input wire logic pin_level,
    output logic supply_rx,
    output logic rsp_valid,
    output logic [20:0] rsp_word
);
    initial begin
        supply_rx = 1'b1;
        rsp_valid = 1'b0;
        rsp_word = 21'h00_0000;
    end

    // ==========================================================
    // one frame, called at a falling edge; h is the half-bit time
    task automatic send(input logic [31:0] f, input int n, input int h, input bit listen);
        logic [20:0] r;
        int w;
        // the host alone opens a transaction; the line idles high between frames
        for (int i = n - 1; i >= 0; i--) begin
            supply_rx <= f[i];
            repeat (h) @(negedge clock);
            supply_rx <= ~f[i];
            repeat (h) @(negedge clock);
        end
        supply_rx <= 1'b1;
        w = 0;
        while (listen && pin_level && w < 5 * h + 10) begin
            @(negedge clock);
            w++;
        end
        // sample mid first half of each cell at the host's own rate
        if (listen && !pin_level) begin
            r = 21'h00_0000;
            repeat (h / 2) @(negedge clock);
            for (int k = 0; k < 21; k++) begin
                r = {r[19:0], pin_level};
                repeat (2 * h) @(negedge clock);
            end
            rsp_word <= r;
            rsp_valid <= 1'b1;
            @(negedge clock);
            rsp_valid <= 1'b0;
        end
        repeat (4 * h + 4) @(negedge clock);
    endtask
endmodule // ssp_host

/* File: test_supply_line_manchester_cmd_port.sv */
// self-checking bench of the supply-line serial command port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_supply_line_manchester_cmd_port;
    typedef struct packed {logic [1:0] kind; logic [5:0] addr; logic [20:0] data;} ssp_note_t;
    logic clock, rstn, disable_line, strap_lo, strap_hi, comm_prev;
    logic angle_pwm_low = 1'b0;
    logic pwm_pin_out, pwm_pin_oe, reg_wr_valid, reg_rd_valid, comm_mode, frame_crc_error;
    logic supply_rx, rsp_valid;
    logic [5:0] reg_wr_addr, reg_rd_addr;
    logic [15:0] reg_wr_data, reg_rd_data;
    logic [20:0] rsp_word;
    logic [15:0] mem [64];
    logic [31:0] lfsr = 32'h0000_fa75;
    int num_errors, num_checks, cycles;
    ssp_note_t notes[$];
    // released pin rises through the pull-up
    wire pin_level = ~pwm_pin_oe;

    ssp_port #(.CNT_W(16), .MIN_HALF(4)) ssp_port_inst (.clock(clock), .rstn(rstn), .clk_en(1'b1),
        .supply_rx(supply_rx), .serial_supply_port_disable(disable_line), .die_strap_low(strap_lo),
        .die_strap_high(strap_hi), .angle_pwm_low(angle_pwm_low), .pwm_pin_in(pin_level),
        .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe), .reg_wr_valid(reg_wr_valid),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_valid(reg_rd_valid),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .comm_mode(comm_mode),
        .frame_crc_error(frame_crc_error));
    ssp_host ssp_host_inst (.clock(clock), .pin_level(pin_level), .supply_rx(supply_rx),
        .rsp_valid(rsp_valid), .rsp_word(rsp_word));

    always #4 clock = ~clock;

    // ==========================================================
    // register store and random sources
    always @(posedge clock) if (reg_wr_valid) mem[reg_wr_addr] <= reg_wr_data;
    assign reg_rd_data = mem[reg_rd_addr];

    // one roller only, so the main flow and the angle stream never race on it
    always @(negedge clock) begin
        lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        angle_pwm_low <= lfsr[7];
    end

    function automatic logic [2:0] chk3(input logic [26:0] p, input int n);
        logic [2:0] c;
        logic fb;
        c = 3'h7;
        for (int i = n - 1; i >= 0; i--) begin
            fb = p[i] ^ c[2];
            c = {c[1:0], 1'b0} ^ ({3{fb}} & 3'h3);
        end
        return c;
    endfunction

    function automatic logic [31:0] wr_frame(input logic [3:0] m, input logic [5:0] a, input logic [15:0] d);
        return {2'b00, 1'b0, m, a, d, chk3({1'b0, m, a, d}, 27)};
    endfunction

    function automatic logic [31:0] rd_frame(input logic [3:0] m, input logic [5:0] a);
        return {16'h0000, 2'b00, 1'b1, m, a, chk3({16'h0000, 1'b1, m, a}, 11)};
    endfunction

    // ==========================================================
    // drivers and notes
    task automatic frame(input logic [31:0] f, input int n, input bit listen);
        ssp_host_inst.send(f, n, 4 + int'(lfsr[3:0]) % 13, listen);
    endtask

    task automatic note(input logic [1:0] k, input logic [5:0] a, input logic [20:0] d);
        notes.push_back('{k, a, d});
    endtask

    task automatic run_die(input logic [1:0] id);
        logic [3:0] me, one, two;
        logic [5:0] a;
        logic [15:0] d;
        me = 4'h1 << id;
        one = 4'h1 << (id + 2'd1);
        two = one | (4'h1 << (id + 2'd2));
        a = {1'b0, lfsr[12:8]};
        d = lfsr[31:16];
        frame(wr_frame(me, a, d), 32, 1'b0);
        frame(wr_frame(lfsr[3:0], 6'h3f, 16'h62d2), 32, 1'b0);
        `CHK("comm_mode", 1'b1, comm_mode)
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            `CHK("pin_oe", 1'b0, pwm_pin_oe)
            `CHK("pin_out", 1'b0, pwm_pin_out)
        end
        note(2'd0, a, {5'h00, d});
        frame(wr_frame(me | two, a, d), 32, 1'b0);
        frame(wr_frame(two, a, ~d), 32, 1'b0);
        d = lfsr[31:16];
        note(2'd0, a, {5'h00, d});
        frame(wr_frame(4'h0, a, d), 32, 1'b0);
        note(2'd2, 6'h00, 21'h00_0000);
        frame(wr_frame(me, a, ~d) ^ 32'h0000_0001, 32, 1'b0);
        note(2'd1, 6'h00, {2'b00, d, chk3({11'h000, d}, 16)});
        frame(rd_frame(me, a), 16, 1'b1);
        frame(rd_frame(one, a), 16, 1'b1);
        note(2'd2, 6'h00, 21'h00_0000);
        frame(rd_frame(me, a) ^ 32'h0000_0002, 16, 1'b1);
        disable_line <= 1'b1;
        frame(wr_frame(4'h0, a, ~d), 32, 1'b0);
        frame(wr_frame(me, a, d) ^ 32'h0000_0001, 32, 1'b0);
        frame(wr_frame(me, 6'h3f, 16'h0000), 32, 1'b0);
        `CHK("comm_mode", 1'b1, comm_mode)
        disable_line <= 1'b0;
        frame(wr_frame(one, 6'h3f, {lfsr[15:1], 1'b1}), 32, 1'b0);
        `CHK("comm_mode", 1'b0, comm_mode)
        frame(wr_frame(me, a, ~d), 32, 1'b0);
    endtask

    // ==========================================================
    // watcher: every result takes the oldest note
    task automatic got(input ssp_note_t g);
        ssp_note_t e;
        e = (notes.size() > 0) ? notes.pop_front() : '1;
        `CHK("result", e, g)
    endtask

    always @(negedge clock) begin
        if (reg_wr_valid === 1'b1) got('{2'd0, reg_wr_addr, {5'h00, reg_wr_data}});
        if (frame_crc_error === 1'b1) got('{2'd2, 6'h00, 21'h00_0000});
        if (rsp_valid === 1'b1) got('{2'd1, 6'h00, rsp_word});
        if (rstn && comm_mode === 1'b0 && comm_prev === 1'b0) `CHK("pin_oe", angle_pwm_low, pwm_pin_oe)
        comm_prev <= comm_mode;
        cycles++;
        if (cycles >= 90000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        disable_line = 1'b0;
        strap_lo = 1'b0;
        strap_hi = 1'b0;
        comm_prev = 1'b0;
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
        // straps are only sampled after a reset, so each identity gets its own reset
        for (int id = 0; id < 4; id++) begin
            @(negedge clock);
            rstn <= 1'b0;
            {strap_hi, strap_lo} <= id[1:0];
            repeat (6) @(negedge clock);
            rstn <= 1'b1;
            @(negedge clock);
            run_die(id[1:0]);
        end
        repeat (20) @(negedge clock);
        `CHK("pending", 0, notes.size())
        report_and_stop();
    end
endmodule // test_supply_line_manchester_cmd_port
